//--- hdl/swl_master.sv
// Single wire bus master: reset, presence, bit slots, speed and CRC check
// Functional notes
// - Master originates reset and all slots; device gives presence and the bits of read slots
// - Master holds reset low 480 us regular or 70 us fast, then listens
// - Master starts every slot with a falling edge
// - Master samples read slot just before read-valid point, at 13 us regular or 1.8 us fast
// - Master runs CRC over every slot bit since crc_clear and flags a zero residue
// - Transaction order: reset, address command, memory command, data
`timescale 1ns/100ps
`include "swl_defines.svh"
module swl_master (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic req_valid,
   output logic req_ready,
   input wire swl_pkg::swl_op_t req_op,
   input wire logic [7:0] req_data,
   input wire logic req_fast,
   input wire logic crc_clear,
   output logic done,
   output logic [7:0] rsp_data,
   output logic presence,
   output logic crc_ok,
   output logic high_speed_flag,
   input wire logic line_in,
   output logic line_out,
   output logic line_oe
);
   localparam logic [15:0] RST_LOW = 16'(`SWL_CYC_US(`SWL_RST_LOW_US));
   localparam logic [15:0] RST_HIGH = 16'(`SWL_CYC_US(`SWL_RST_HIGH_US));
   localparam logic [15:0] PRES_SMP = 16'(`SWL_CYC_US(`SWL_PRES_SAMPLE_US));
   localparam logic [15:0] SLOT = 16'(`SWL_CYC_US(`SWL_SLOT_US));
   localparam logic [15:0] W1_LOW = 16'(`SWL_CYC_US(`SWL_W1_LOW_US));
   localparam logic [15:0] W0_LOW = 16'(`SWL_CYC_US(`SWL_W0_LOW_US));
   localparam logic [15:0] RD_LOW = 16'(`SWL_CYC_US(`SWL_RD_LOW_US));
   localparam logic [15:0] RD_SMP = 16'(`SWL_CYC_US(`SWL_RD_SAMPLE_US));
   localparam logic [15:0] REC = 16'(`SWL_CYC_US(`SWL_REC_US));
   localparam logic [15:0] HS_RST_LOW = 16'(`SWL_CYC_TUS(`SWL_HS_RST_LOW_TUS));
   localparam logic [15:0] HS_RST_HIGH = 16'(`SWL_CYC_TUS(`SWL_HS_RST_HIGH_TUS));
   localparam logic [15:0] HS_PRES_SMP = 16'(`SWL_CYC_TUS(`SWL_HS_PRES_SAMPLE_TUS));
   localparam logic [15:0] HS_SLOT = 16'(`SWL_CYC_TUS(`SWL_HS_SLOT_TUS));
   localparam logic [15:0] HS_W1_LOW = 16'(`SWL_CYC_TUS(`SWL_HS_W1_LOW_TUS));
   localparam logic [15:0] HS_W0_LOW = 16'(`SWL_CYC_TUS(`SWL_HS_W0_LOW_TUS));
   localparam logic [15:0] HS_RD_LOW = 16'(`SWL_CYC_TUS(`SWL_HS_RD_LOW_TUS));
   localparam logic [15:0] HS_RD_SMP = 16'(`SWL_CYC_TUS(`SWL_HS_RD_SAMPLE_TUS));
   localparam logic [15:0] HS_REC = 16'(`SWL_CYC_TUS(`SWL_HS_REC_TUS));

   swl_pkg::swl_state_t state;
   swl_pkg::swl_op_t op;
   logic [15:0] cnt;
   logic [15:0] low_len;
   logic [15:0] smp_at;
   logic [15:0] end_at;
   logic [2:0] bit_idx;
   logic [7:0] shreg;
   logic line_s1;
   logic line_s2;
   logic last_bit;
   logic slot_bit;
   logic fast;
   swl_crc_if crc_bus ();

   // Selects one timing set by speed
   function automatic logic [15:0] pick(input logic f, input logic [15:0] reg_t,
                                       input logic [15:0] hs_t);
      pick = f ? hs_t : reg_t;
   endfunction : pick

   swl_crc8 u_crc (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .crc_port(crc_bus)
   );

   // Two flip-flop synchroniser on the bus pin
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         line_s1 <= 1'b1;
         line_s2 <= 1'b1;
      end else begin
         line_s1 <= line_in;
         line_s2 <= line_s1;
      end
   end

   // one operation at a time, taken only when idle
   assign req_ready = (state == swl_pkg::SWL_IDLE);
   assign fast = high_speed_flag;
   assign slot_bit = shreg[0];
   assign last_bit = (bit_idx == 3'h7);
   assign line_out = 1'b0; // Open drain: only ever pulls low

   // timing set follows the speed flag for every waveform
   always_comb begin
      low_len = 16'h0000;
      smp_at = 16'h0000;
      end_at = 16'h0000;
      unique case (op)
         swl_pkg::SWL_OP_RESET: begin
            low_len = pick(fast, RST_LOW, HS_RST_LOW);
            smp_at = low_len + pick(fast, PRES_SMP, HS_PRES_SMP);
            end_at = low_len + pick(fast, RST_HIGH, HS_RST_HIGH);
         end
         swl_pkg::SWL_OP_WRITE: begin
            low_len = slot_bit ? pick(fast, W1_LOW, HS_W1_LOW) : pick(fast, W0_LOW, HS_W0_LOW);
            smp_at = pick(fast, SLOT, HS_SLOT);
            end_at = pick(fast, SLOT, HS_SLOT) + pick(fast, REC, HS_REC);
         end
         swl_pkg::SWL_OP_READ: begin
            low_len = pick(fast, RD_LOW, HS_RD_LOW);
            smp_at = pick(fast, RD_SMP, HS_RD_SMP);
            end_at = pick(fast, SLOT, HS_SLOT) + pick(fast, REC, HS_REC);
         end
         default: begin
            low_len = 16'h0000;
         end
      endcase
   end

   // slot sequencer: every slot begins with the master pulling low
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= swl_pkg::SWL_IDLE;
         op <= swl_pkg::SWL_OP_RESET;
         cnt <= 16'h0000;
         bit_idx <= 3'h0;
         shreg <= 8'h00;
         line_oe <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         unique case (state)
            swl_pkg::SWL_IDLE: begin
               if (req_valid && req_op != swl_pkg::SWL_OP_SPEED) begin
                  op <= req_op;
                  shreg <= req_data;
                  bit_idx <= 3'h0;
                  cnt <= 16'h0000;
                  line_oe <= 1'b1;
                  state <= swl_pkg::SWL_LOW;
               end else if (req_valid) begin
                  done <= 1'b1;
               end
            end
            swl_pkg::SWL_LOW: begin
               cnt <= cnt + 16'h0001;
               if (cnt + 16'h0001 >= low_len) begin
                  line_oe <= 1'b0;
                  state <= swl_pkg::SWL_WAIT;
               end
            end
            swl_pkg::SWL_WAIT: begin
               cnt <= cnt + 16'h0001;
               if (cnt + 16'h0001 >= smp_at) begin
                  state <= swl_pkg::SWL_SAMPLE;
               end
            end
            swl_pkg::SWL_SAMPLE: begin
               cnt <= cnt + 16'h0001;
               // bits shift out and in least significant first
               if (op != swl_pkg::SWL_OP_RESET) begin
                  shreg <= {(op == swl_pkg::SWL_OP_READ) ? line_s2 : slot_bit, shreg[7:1]};
               end
               state <= swl_pkg::SWL_TAIL;
            end
            swl_pkg::SWL_TAIL: begin
               cnt <= cnt + 16'h0001;
               if (cnt + 16'h0001 >= end_at) begin
                  cnt <= 16'h0000;
                  if (op == swl_pkg::SWL_OP_RESET || last_bit) begin
                     done <= 1'b1;
                     state <= swl_pkg::SWL_IDLE;
                  end else begin
                     bit_idx <= bit_idx + 3'h1;
                     line_oe <= 1'b1;
                     state <= swl_pkg::SWL_LOW;
                  end
               end
            end
            default: begin
               state <= swl_pkg::SWL_IDLE;
            end
         endcase
      end
   end

   // Presence and read result registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         presence <= 1'b0;
         rsp_data <= 8'h00;
      end else begin
         if (state == swl_pkg::SWL_SAMPLE && op == swl_pkg::SWL_OP_RESET) begin
            presence <= !line_s2;
         end
         if (state == swl_pkg::SWL_TAIL && op != swl_pkg::SWL_OP_RESET && last_bit
             && cnt + 16'h0001 >= end_at) begin
            rsp_data <= shreg;
         end
      end
   end

   // speed flag: written from req_fast on a speed request; a bus reset never changes it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         high_speed_flag <= 1'b0;
      end else if (state == swl_pkg::SWL_IDLE && req_valid && req_op == swl_pkg::SWL_OP_SPEED) begin
         high_speed_flag <= req_fast;
      end else if (state == swl_pkg::SWL_LOW && op == swl_pkg::SWL_OP_RESET && !fast) begin
         high_speed_flag <= 1'b0;
      end
   end

   // CRC over bits seen on the wire, both directions
   assign crc_bus.clear = crc_clear && state == swl_pkg::SWL_IDLE;
   assign crc_bus.shift = state == swl_pkg::SWL_SAMPLE && op != swl_pkg::SWL_OP_RESET;
   assign crc_bus.bit_in = (op == swl_pkg::SWL_OP_READ) ? line_s2 : slot_bit;
   // true-form CRC makes the residue zero after 64 bits
   assign crc_ok = (crc_bus.crc == 8'h00);
endmodule : swl_master

//--- hdl/swl_defines.svh
// Timing and command constants for the single wire bus master
`ifndef SWL_DEFINES_SVH
`define SWL_DEFINES_SVH
`define SWL_CLK_MHZ 100
// Regular speed times in microseconds
`define SWL_RST_LOW_US 480
`define SWL_RST_HIGH_US 480
`define SWL_SLOT_US 70
`define SWL_W1_LOW_US 6
`define SWL_W0_LOW_US 60
`define SWL_RD_LOW_US 2
`define SWL_RD_SAMPLE_US 13
`define SWL_REC_US 5
`define SWL_PRES_SAMPLE_US 70
// High speed times in tenths of a microsecond
`define SWL_HS_RST_LOW_TUS 700
`define SWL_HS_RST_HIGH_TUS 480
`define SWL_HS_SLOT_TUS 100
`define SWL_HS_W1_LOW_TUS 10
`define SWL_HS_W0_LOW_TUS 75
`define SWL_HS_RD_LOW_TUS 10
`define SWL_HS_RD_SAMPLE_TUS 18
`define SWL_HS_REC_TUS 20
`define SWL_HS_PRES_SAMPLE_TUS 85
// Cycle counts
`define SWL_CYC_US(t) ((t) * `SWL_CLK_MHZ)
`define SWL_CYC_TUS(t) ((t) * `SWL_CLK_MHZ / 10)
// Address level command codes and CRC polynomial
`define SWL_CMD_READ_ID 8'h33
`define SWL_CMD_MATCH 8'h55
`define SWL_CMD_SEARCH 8'hF0
`define SWL_CMD_SKIP 8'hCC
`define SWL_CMD_HS_SKIP 8'h3C
`define SWL_CMD_HS_MATCH 8'h69
`define SWL_CMD_RESUME 8'hA5
`define SWL_CRC_POLY 8'h8C
`endif

//--- hdl/swl_pkg.sv
// Types for the single wire bus master
package swl_pkg;
   typedef enum logic [1:0] {SWL_OP_RESET, SWL_OP_WRITE, SWL_OP_READ, SWL_OP_SPEED} swl_op_t;
   typedef enum logic [2:0] {SWL_IDLE, SWL_LOW, SWL_WAIT, SWL_SAMPLE, SWL_TAIL} swl_state_t;
endpackage : swl_pkg

//--- hdl/swl_crc_if.sv
// Signals between the bus master and its CRC unit
`timescale 1ns/100ps
interface swl_crc_if;
   logic clear;
   logic shift;
   logic bit_in;
   logic [7:0] crc;
   modport master (output clear, output shift, output bit_in, input crc);
   modport unit (input clear, input shift, input bit_in, output crc);
endinterface : swl_crc_if

//--- hdl/swl_crc8.sv
// Serial 8-bit CRC, X^8+X^5+X^4+1, LSB first
`timescale 1ns/100ps
`include "swl_defines.svh"
module swl_crc8 (
   input wire logic ref_clk,
   input wire logic rst_n,
   swl_crc_if.unit crc_port
);
   logic [7:0] crc;
   logic fb;
   assign fb = crc[0] ^ crc_port.bit_in;
   assign crc_port.crc = crc;
   // Shift register with reflected polynomial
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         crc <= 8'h00;
      end else if (crc_port.clear) begin
         crc <= 8'h00;
      end else if (crc_port.shift) begin
         crc <= (crc >> 1) ^ (fb ? `SWL_CRC_POLY : 8'h00);
      end
   end
endmodule : swl_crc8

//--- testbench/swl_master_chk.sv
// Port assertions for the single wire bus master
`timescale 1ns/100ps
module swl_master_chk (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire swl_pkg::swl_op_t req_op,
   input wire logic [7:0] req_data,
   input wire logic crc_clear,
   input wire logic done,
   input wire logic crc_ok,
   input wire logic high_speed_flag,
   input wire logic line_out,
   input wire logic line_oe
);
   logic [15:0] lo_cnt;
   swl_pkg::swl_op_t op_q;
   // Length of the current low pulse and last operation taken
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         lo_cnt <= 16'h0000;
         op_q <= swl_pkg::SWL_OP_SPEED;
      end else begin
         lo_cnt <= line_oe ? lo_cnt + 16'h0001 : 16'h0000;
         if (req_valid && req_ready) op_q <= req_op;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Slot opens soon and its low part stays short
   sequence s_short_low;
      ##[1:3] line_oe ##[1:200] !line_oe;
   endsequence
   drive_low_only_a: assert property (line_out == 1'b0) else $error("line driven high");
   reset_low_min_a: assert property (
      $fell(line_oe) && op_q == swl_pkg::SWL_OP_RESET
      |-> lo_cnt >= (high_speed_flag ? 16'h12C0 : 16'hBB80)) else $error("reset too short");
   slot_start_a: assert property (
      req_valid && req_ready && req_op != swl_pkg::SWL_OP_SPEED |-> ##[1:3] line_oe)
      else $error("slot not started");
   lsb_first_a: assert property (
      req_valid && req_ready && req_op == swl_pkg::SWL_OP_WRITE && req_data[0]
      && high_speed_flag |-> s_short_low) else $error("first slot not bit 0");
   read_slot_a: assert property (
      req_valid && req_ready && req_op == swl_pkg::SWL_OP_READ && high_speed_flag
      |-> s_short_low) else $error("read low too long");
   done_pulse_a: assert property (done |=> !done) else $error("done held");
   crc_clear_a: assert property (
      crc_clear && req_ready && !req_valid |=> crc_ok) else $error("crc not cleared");
endmodule : swl_master_chk
bind swl_master swl_master_chk u_swl_master_chk (.ref_clk(ref_clk), .rst_n(rst_n),
   .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_data(req_data),
   .crc_clear(crc_clear), .done(done), .crc_ok(crc_ok), .high_speed_flag(high_speed_flag),
   .line_out(line_out), .line_oe(line_oe));

//--- testbench/swl_dev_model.sv
// Behavioural single wire device with an identity ROM
`timescale 1ns/100ps
module swl_dev_model #(
   parameter bit FAST0 = 1'b1
) (
   input wire logic line,
   input wire logic [63:0] rom_id,
   output logic pull
);
   logic fast, rd_en, resume_select_flag;
   logic [7:0] cmd;
   int nb, n;
   realtime t0;
   // Slots and resets timed from falling edges; presence timed from the rising edge that ends a reset
   initial begin
      pull = 1'b0;
      fast = FAST0; // Left fast by an earlier fast skip
      rd_en = 1'b0;
      resume_select_flag = 1'b0;
      nb = 0;
      n = 0;
      forever begin
         @(negedge line);
         t0 = $realtime;
         if (rd_en) pull = ~rom_id[n];
         #(fast ? 3000 : 30000);
         pull = 1'b0;
         if (rd_en) n++;
         else cmd = {line, cmd[7:1]};
         nb++;
         if (line === 1'b0) @(posedge line);
         if ($realtime - t0 > (fast ? 16000 : 120000)) begin
            if ($realtime - t0 >= 480000) fast = 1'b0;
            rd_en = 1'b0;
            nb = 0;
            n = 0;
            #(fast ? 3000 : 30000) pull = 1'b1;
            #(fast ? 12000 : 120000) pull = 1'b0;
         end else if (nb == 8 && !rd_en) begin
            rd_en = (cmd == 8'h33);
            if (cmd == 8'h3C) fast = 1'b1;
            // fast select of this lone device; a fast device stays fast
            if (cmd == 8'h69) fast = 1'b1;
            // addressing marks the device so that resume acts as skip
            if (cmd == 8'h55 || cmd == 8'hF0 || cmd == 8'h69) resume_select_flag = 1'b1;
            // lone device: no other address clears it; no memory layer
         end
      end
   end
endmodule : swl_dev_model

//--- testbench/swl_master_tb_top.sv
// Testbench for the single wire bus master
`timescale 1ns/100ps
module swl_master_tb_top;
   typedef struct packed {swl_pkg::swl_op_t op; logic [7:0] v;} swl_exp_t;
   logic ref_clk, rst_n, req_valid, req_fast, crc_clear, req_ready, done, presence;
   logic crc_ok, high_speed_flag, line_out, line_oe, dev_pull;
   logic [7:0] req_data, rsp_data, crc;
   logic [63:0] rom;
   swl_pkg::swl_op_t req_op;
   swl_exp_t exp_q[$], e_cur;
   int n_errors = 0;
   int samples_checked = 0;
   // Open drain line with pull-up
   wire line = !(line_oe === 1'b1 || dev_pull === 1'b1);
   swl_master u_swl_master (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid),
      .req_ready(req_ready), .req_op(req_op), .req_data(req_data), .req_fast(req_fast),
      .crc_clear(crc_clear), .done(done), .rsp_data(rsp_data), .presence(presence),
      .crc_ok(crc_ok), .high_speed_flag(high_speed_flag), .line_in(line),
      .line_out(line_out), .line_oe(line_oe));
   swl_dev_model u_swl_dev_model (.line(line), .rom_id(rom), .pull(dev_pull));
   // Clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic stop_test();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test
   // Issue one operation, note its result, wait for done
   task automatic do_op(input swl_pkg::swl_op_t op, input logic [7:0] d, input logic [7:0] e);
      int n = 0;
      @(posedge ref_clk);
      req_op <= op;
      req_data <= d;
      req_fast <= d[0];
      req_valid <= 1'b1;
      @(posedge ref_clk);
      req_valid <= 1'b0;
      exp_q.push_back('{op, e});
      do begin
         @(negedge ref_clk);
         n++;
      end while (done !== 1'b1 && n < 20000);
      if (n >= 20000) begin
         n_errors++;
         stop_test();
      end
   endtask : do_op
   // Compare each finished operation with the oldest note
   always @(negedge ref_clk) begin
      if (done === 1'b1 && exp_q.size() > 0) begin
         e_cur = exp_q.pop_front();
         case (e_cur.op)
            swl_pkg::SWL_OP_RESET: chk({7'h00, presence}, e_cur.v);
            swl_pkg::SWL_OP_SPEED: chk({7'h00, high_speed_flag}, e_cur.v);
            default: chk(rsp_data, e_cur.v);
         endcase
      end
   end
   // Main sequence
   initial begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req_op = swl_pkg::SWL_OP_RESET;
      req_data = 8'h00;
      req_fast = 1'b0;
      crc_clear = 1'b0;
      void'($urandom(32'h626fa470));
      rom = {$urandom, $urandom};
      crc = 8'h00;
      for (int i = 0; i < 56; i++) crc = (crc >> 1) ^ ((crc[0] ^ rom[i]) ? 8'h8C : 8'h00);
      rom[63:56] = crc;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      do_op(swl_pkg::SWL_OP_SPEED, 8'h01, 8'h01);
      do_op(swl_pkg::SWL_OP_RESET, 8'h00, 8'h01);
      chk({7'h00, high_speed_flag}, 8'h01);
      do_op(swl_pkg::SWL_OP_WRITE, 8'h33, 8'h33);
      @(posedge ref_clk) crc_clear <= 1'b1;
      @(posedge ref_clk) crc_clear <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         do_op(swl_pkg::SWL_OP_READ, 8'h00, rom[8*i +: 8]);
         // after 56 bits the residue equals the stored byte
         if (i == 6) chk({7'h00, crc_ok}, {7'h00, rom[63:56] == 8'h00});
      end
      chk({7'h00, crc_ok}, 8'h01);
      do_op(swl_pkg::SWL_OP_SPEED, 8'h00, 8'h00);
      stop_test();
   end
   // Watchdog just beyond the expected run of about 0.98 ms
   initial begin
      #1050000;
      n_errors++;
      stop_test();
   end
endmodule : swl_master_tb_top
